// >>> rsb_consts.vh
/*
 header of constants for the radio status register bank: register
 addresses, field positions, reset values and identity codes.
 assumes it is included by bare name from the bank module.
*/
`ifndef RSB_CONSTS_VH
`define RSB_CONSTS_VH

// register addresses
`define RSB_ADDR_CTRL_FLAGS_HI   8'h8D
`define RSB_ADDR_CTRL_FLAGS_LO   8'h8E
`define RSB_ADDR_TX_LEVEL        8'h8F
`define RSB_ADDR_RX_LEVEL        8'h90
`define RSB_ADDR_RCO_HI          8'h94
`define RSB_ADDR_RCO_LO          8'h95
`define RSB_ADDR_SYN_AMP         8'h99
`define RSB_ADDR_SYN_FREQ        8'h9A
`define RSB_ADDR_TX_BOOK         8'h9C
`define RSB_ADDR_RX_BOOK         8'h9D
`define RSB_ADDR_FREQ_OFS        8'h9E
`define RSB_ADDR_PQ              8'h9F
`define RSB_ADDR_SQ_CS           8'hA0
`define RSB_ADDR_SS_SYNC         8'hA2
`define RSB_ADDR_LEN_HI          8'hA4
`define RSB_ADDR_LEN_LO          8'hA5
`define RSB_ADDR_CHK3            8'hA6
`define RSB_ADDR_CHK2            8'hA7
`define RSB_ADDR_CHK1            8'hA8
`define RSB_ADDR_CHK0            8'hA9
`define RSB_ADDR_SRC             8'hAA
`define RSB_ADDR_DST             8'hAB
`define RSB_ADDR_SS_RUN          8'hEF
`define RSB_ADDR_PART            8'hF0
`define RSB_ADDR_REV             8'hF1
`define RSB_ADDR_IRQ3            8'hFA
`define RSB_ADDR_IRQ2            8'hFB
`define RSB_ADDR_IRQ1            8'hFC
`define RSB_ADDR_IRQ0            8'hFD

// reset values
`define RSB_RST_CTRL_FLAGS_HI    8'h52
`define RSB_RST_CTRL_FLAGS_LO    8'h07
`define RSB_RST_RCO_HI           8'h70
`define RSB_RST_IRQ              32'h00090500
`define RSB_RST_ZERO             8'h00

// field positions
`define RSB_BIT_RX_EMPTY         1
`define RSB_BIT_CAL_ERROR        0
`define RSB_BIT_NACK             2

// identity codes: arbitrary neutral values
`define RSB_PART_CODE            8'h5A
`define RSB_REV_CODE             8'h01

`endif

// >>> rsb_status_bank.v
/*
 radio status register bank: registers status values produced by the
 modem, fifos and calibrators, and answers host reads by address.
 assumes producers run on clk and present level values; the serial
 host port decodes reads into rd_addr and write strobes, which are ignored.
*/
`timescale 1ns/1ps
`include "rsb_consts.vh"

// How it works
// - rx empty flag set when rx count zero
// - bit 0 reports rc calibration error
// - tx fifo byte count readable
// - rx fifo byte count readable
// - tx sequence number in bits 5:4
// - retransmission count in bits 3:0
// - received nack captured into bit 2
// - received sequence number in bits 1:0
// - preamble quality stored per packet
// - sync quality low, carrier sense bit 7
// - signal strength latched at sync detect
// - length high byte first, low next
// - four check bytes, byte three first
// - source address byte stored
// - destination address byte follows source
// - running signal strength updated every cycle
// - irq word most significant byte first
// - rc trim word in bits 7:4
// - amplitude result thermometer to binary
// - capbank result thermometer to binary

module rsb_status_bank #(
   parameter PART_CODE = `RSB_PART_CODE, // arbitrary value
   parameter REV_CODE  = `RSB_REV_CODE   // arbitrary value
) (
   input  wire        clk,
   input  wire        rst_b,
   input  wire [7:0]  rd_addr,                  // read address from serial port
   input  wire        wr_en,                    // host write strobe, ignored
   input  wire [7:0]  wr_data,                  // host write data, ignored
   input  wire [6:0]  controller_state,         // main controller state
   input  wire        crystal_osc_running,      // oscillator running
   input  wire        cal_error,                // rc calibrator error
   input  wire        antenna_select,           // current antenna
   input  wire        cal_ok,                   // rc calibration done
   input  wire [7:0]  transmit_queue_count,     // tx fifo fill
   input  wire [7:0]  receive_queue_count,      // rx fifo fill
   input  wire [3:0]  rc_trim_word_result,      // rc trim word
   input  wire [4:0]  rc_feedback_word_result,  // rc feedback word
   input  wire [14:0] synth_amplitude_therm,    // amplitude thermometer code
   input  wire [126:0] synth_capbank_therm,     // capbank thermometer code
   input  wire [1:0]  transmit_sequence_number, // current tx sequence
   input  wire [3:0]  retransmission_count,     // retries for last tx
   input  wire        tx_book_update,           // tx bookkeeping strobe
   input  wire        pkt_done,                 // received packet complete
   input  wire        received_negative_ack,    // nack of packet
   input  wire [1:0]  received_sequence_number, // sequence of packet
   input  wire [7:0]  frequency_offset_value,   // frequency correction
   input  wire [7:0]  preamble_quality,         // preamble quality
   input  wire [6:0]  sync_quality,             // sync quality
   input  wire        carrier_sense,            // carrier sense
   input  wire        sync_detected,            // sync detect complete pulse
   input  wire [7:0]  live_signal_strength,     // running strength
   input  wire [14:0] received_length,          // packet length
   input  wire [31:0] check_bytes,              // check bytes of packet
   input  wire [7:0]  source_address_byte,      // source address
   input  wire [7:0]  destination_address_byte, // destination address
   input  wire [31:0] irq_level,                // interrupt status word
   output reg  [7:0]  rd_data                   // registered read data
);

   // captured registers
   reg  [7:0]  flags_hi_reg;   // state flags high
   reg  [7:0]  flags_lo_reg;   // state flags low
   reg  [7:0]  tx_level_reg;   // tx count
   reg  [7:0]  rx_level_reg;   // rx count
   reg  [3:0]  rwt_reg;        // rc trim word
   reg  [4:0]  rfb_reg;        // rc feedback word
   reg  [3:0]  amp_reg;        // amplitude binary
   reg  [6:0]  freq_reg;       // capbank binary
   reg  [1:0]  txseq_reg;      // tx sequence
   reg  [3:0]  retx_reg;       // retries
   reg         nack_reg;       // received nack
   reg  [1:0]  rxseq_reg;      // received sequence
   reg  [7:0]  fofs_reg;       // frequency correction
   reg  [7:0]  pq_reg;         // preamble quality
   reg  [7:0]  sqcs_reg;       // sync quality and carrier
   reg  [7:0]  ss_sync_reg;    // latched strength
   reg  [7:0]  ss_run_reg;     // running strength
   reg  [14:0] len_reg;        // length
   reg  [31:0] chk_reg;        // check bytes
   reg  [7:0]  src_reg;        // source address
   reg  [7:0]  dst_reg;        // destination address
   reg  [31:0] irq_reg;        // interrupt word
   reg  [7:0]  rd_next;        // next read data

   // ones counted in each thermometer code; a part-select cannot be
   // taken straight off a function call, so the counts live on wires
   wire [7:0]  amp_ones;       // ones in the amplitude code
   wire [7:0]  cap_ones;       // ones in the capbank code

   // count ones of a thermometer code into binary
   function [7:0] therm_count;
      input [126:0] t;
      integer i;
      begin
         therm_count = 8'h00;
         for (i = 0; i < 127; i = i + 1) begin
            therm_count = therm_count + {7'h00, t[i]};
         end
      end
   endfunction

   // both codes counted once, read by the calibration process
   assign amp_ones = therm_count({112'h0, synth_amplitude_therm});
   assign cap_ones = therm_count(synth_capbank_therm);

   // controller flags and fifo levels follow every cycle
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_hi_reg <= `RSB_RST_CTRL_FLAGS_HI;
         flags_lo_reg <= `RSB_RST_CTRL_FLAGS_LO;
         tx_level_reg <= `RSB_RST_ZERO;
         rx_level_reg <= `RSB_RST_ZERO;
         ss_run_reg   <= `RSB_RST_ZERO;
         fofs_reg     <= `RSB_RST_ZERO;
         irq_reg      <= `RSB_RST_IRQ;
      end else begin
         flags_hi_reg <= {3'h0, antenna_select, cal_ok, 1'b0,
                          (receive_queue_count == 8'h00),
                          cal_error};
         flags_lo_reg <= {controller_state, crystal_osc_running};
         tx_level_reg <= transmit_queue_count;
         rx_level_reg <= receive_queue_count;
         ss_run_reg   <= live_signal_strength;
         fofs_reg     <= frequency_offset_value;
         irq_reg      <= irq_level;
      end
   end

   // calibration results, amplitude and capbank converted to binary
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rwt_reg  <= 4'h7;
         rfb_reg  <= 5'h00;
         amp_reg  <= 4'h0;
         freq_reg <= 7'h00;
      end else begin
         rwt_reg  <= rc_trim_word_result;
         rfb_reg  <= rc_feedback_word_result;
         // counts above the field maximum saturate
         amp_reg  <= (amp_ones > 8'h0F) ? 4'hF : amp_ones[3:0];
         freq_reg <= (cap_ones > 8'h7F) ? 7'h7F : cap_ones[6:0];
      end
   end

   // transmit bookkeeping taken on its strobe
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         txseq_reg <= 2'h0;
         retx_reg  <= 4'h0;
      end else if (tx_book_update) begin
         txseq_reg <= transmit_sequence_number;
         retx_reg  <= retransmission_count;
      end
   end

   // signal strength caught when sync detection completes
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ss_sync_reg <= `RSB_RST_ZERO;
      end else if (sync_detected) begin
         ss_sync_reg <= live_signal_strength;
      end
   end

   // received packet fields caught at packet completion
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nack_reg  <= 1'b0;
         rxseq_reg <= 2'h0;
         pq_reg    <= `RSB_RST_ZERO;
         sqcs_reg  <= `RSB_RST_ZERO;
         len_reg   <= 15'h0000;
         chk_reg   <= 32'h00000000;
         src_reg   <= `RSB_RST_ZERO;
         dst_reg   <= `RSB_RST_ZERO;
      end else if (pkt_done) begin
         nack_reg  <= received_negative_ack;
         rxseq_reg <= received_sequence_number;
         pq_reg    <= preamble_quality;
         sqcs_reg  <= {carrier_sense, sync_quality};
         len_reg   <= received_length;
         chk_reg   <= check_bytes;
         src_reg   <= source_address_byte;
         dst_reg   <= destination_address_byte;
      end
   end

   // read decode; writes have no path into any register
   always @* begin
      case (rd_addr)
         `RSB_ADDR_CTRL_FLAGS_HI : rd_next = flags_hi_reg;
         `RSB_ADDR_CTRL_FLAGS_LO : rd_next = flags_lo_reg;
         `RSB_ADDR_TX_LEVEL      : rd_next = tx_level_reg;
         `RSB_ADDR_RX_LEVEL      : rd_next = rx_level_reg;
         `RSB_ADDR_RCO_HI        : rd_next = {rwt_reg, rfb_reg[4:1]};
         `RSB_ADDR_RCO_LO        : rd_next = {rfb_reg[0], 7'h00};
         `RSB_ADDR_SYN_AMP       : rd_next = {4'h0, amp_reg};
         `RSB_ADDR_SYN_FREQ      : rd_next = {1'b0, freq_reg};
         `RSB_ADDR_TX_BOOK       : rd_next = {2'h0, txseq_reg, retx_reg};
         `RSB_ADDR_RX_BOOK       : rd_next = {5'h00, nack_reg, rxseq_reg};
         `RSB_ADDR_FREQ_OFS      : rd_next = fofs_reg;
         `RSB_ADDR_PQ            : rd_next = pq_reg;
         `RSB_ADDR_SQ_CS         : rd_next = sqcs_reg;
         `RSB_ADDR_SS_SYNC       : rd_next = ss_sync_reg;
         `RSB_ADDR_LEN_HI        : rd_next = {1'b0, len_reg[14:8]};
         `RSB_ADDR_LEN_LO        : rd_next = len_reg[7:0];
         `RSB_ADDR_CHK3          : rd_next = chk_reg[31:24];
         `RSB_ADDR_CHK2          : rd_next = chk_reg[23:16];
         `RSB_ADDR_CHK1          : rd_next = chk_reg[15:8];
         `RSB_ADDR_CHK0          : rd_next = chk_reg[7:0];
         `RSB_ADDR_SRC           : rd_next = src_reg;
         `RSB_ADDR_DST           : rd_next = dst_reg;
         `RSB_ADDR_SS_RUN        : rd_next = ss_run_reg;
         `RSB_ADDR_PART          : rd_next = PART_CODE;
         `RSB_ADDR_REV           : rd_next = REV_CODE;
         `RSB_ADDR_IRQ3          : rd_next = irq_reg[31:24];
         `RSB_ADDR_IRQ2          : rd_next = irq_reg[23:16];
         `RSB_ADDR_IRQ1          : rd_next = irq_reg[15:8];
         `RSB_ADDR_IRQ0          : rd_next = irq_reg[7:0];
         default                 : rd_next = 8'h00;
      endcase
   end

   // read data register
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_next;
      end
   end

endmodule // rsb_status_bank

// >>> rsb_status_bank_checker.sv
/*
 checker for the radio status register bank: read answers against the
 status inputs two rising edges earlier, three for the rx bookkeeping read. assumes it is bound to the bank.
*/
`timescale 1ns/1ps
module rsb_status_bank_checker #(
   parameter PART_CODE = 8'h5A, // arbitrary value
   parameter REV_CODE  = 8'h01  // arbitrary value
) (
   input wire        clk,
   input wire        rst_b,
   input wire [7:0]  rd_addr,
   input wire [7:0]  receive_queue_count,
   input wire [7:0]  transmit_queue_count,
   input wire        cal_error,
   input wire        pkt_done,
   input wire        sync_detected,
   input wire        received_negative_ack,
   input wire [1:0]  received_sequence_number,
   input wire [7:0]  live_signal_strength,
   input wire [31:0] irq_level,
   input wire [7:0]  rd_data
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // sync capture then a read of the latched strength
   sequence s_sync_read; sync_detected ##1 rd_addr == 8'hA2; endsequence
   // packet capture, a quiet cycle, then a read of the bookkeeping
   sequence s_pkt_read; pkt_done ##1 !pkt_done ##1 rd_addr == 8'h9D; endsequence
   property p_rx_empty; rd_addr == 8'h8D |=> rd_data[1] == ($past(receive_queue_count, 2) == 8'h00); endproperty
   a_rx_empty: assert property (p_rx_empty) else $error("empty flag wrong");
   property p_cal_err; rd_addr == 8'h8D |=> rd_data[0] == $past(cal_error, 2); endproperty
   a_cal_err: assert property (p_cal_err) else $error("error flag wrong");
   property p_tx_lvl; rd_addr == 8'h8F |=> rd_data == $past(transmit_queue_count, 2); endproperty
   a_tx_lvl: assert property (p_tx_lvl) else $error("tx level wrong");
   property p_rx_lvl; rd_addr == 8'h90 |=> rd_data == $past(receive_queue_count, 2); endproperty
   a_rx_lvl: assert property (p_rx_lvl) else $error("rx level wrong");
   property p_pkt; s_pkt_read |=> rd_data == {5'h00, $past(received_negative_ack, 3), $past(received_sequence_number, 3)};
   endproperty
   a_pkt: assert property (p_pkt) else $error("rx bookkeeping wrong");
   property p_sync; s_sync_read |=> rd_data == $past(live_signal_strength, 2); endproperty
   a_sync: assert property (p_sync) else $error("latched strength wrong");
   property p_live; rd_addr == 8'hEF |=> rd_data == $past(live_signal_strength, 2); endproperty
   a_live: assert property (p_live) else $error("running strength wrong");
   property p_irq; rd_addr == 8'hFA |=> rd_data == $past(irq_level[31:24], 2); endproperty
   a_irq: assert property (p_irq) else $error("irq top byte wrong");
   property p_unmapped; rd_addr == 8'hA1 || rd_addr == 8'h00 |=> rd_data == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ident; rd_addr == 8'hF0 ##1 rd_addr == 8'hF1 |-> rd_data == PART_CODE ##1 rd_data == REV_CODE; endproperty
   a_ident: assert property (p_ident) else $error("identity wrong");
endmodule // rsb_status_bank_checker
bind rsb_status_bank rsb_status_bank_checker #(.PART_CODE(PART_CODE), .REV_CODE(REV_CODE)) chk_u (.*);

// >>> rsb_host.sv
/*
 host model: issues register reads and writes, notes expected read data.
 assumes the bench compares one rising edge after each read address.
*/
`timescale 1ns/1ps
module rsb_host (
   output reg  [7:0] rd_addr,
   output reg        wr_en,
   output reg  [7:0] wr_data,
   output reg        req_live,
   input  wire       clk
);
   logic [7:0] exp_q[$]; // expected read data, oldest first
   initial begin
      {rd_addr, wr_en, wr_data, req_live} = 18'h00000;
   end
   // read: address held a whole cycle, answer due at the next rising edge
   task rd(input [7:0] a, input [7:0] e);
      exp_q.push_back(e);
      @(negedge clk);
      rd_addr = a;
      req_live = 1'b1;
   endtask
   // write strobe for one cycle, then the data lines show the inverse
   task wr(input [7:0] a, input [7:0] d);
      @(negedge clk);
      {req_live, wr_en, rd_addr, wr_data} = {2'b01, a, d};
      @(negedge clk);
      {wr_en, wr_data} = {1'b0, ~d};
   endtask
   // quiet cycle, nothing awaited
   task idle;
      @(negedge clk);
      req_live = 1'b0;
   endtask
endmodule // rsb_host

// >>> test_radio_status_register_bank.sv
/*
 bench for the radio status register bank: host model reads, a monitor
 compares each answer. assumes the bound checker and host model files.
*/
`timescale 1ns/1ps
module test_radio_status_register_bank;
   reg          clk, rst_b;
   wire [7:0]   rd_addr, wr_data, rd_data;
   wire         wr_en, req_live;
   reg  [6:0]   controller_state, sync_quality;
   reg          crystal_osc_running, cal_error, antenna_select, cal_ok, tx_book_update, pkt_done;
   reg          received_negative_ack, carrier_sense, sync_detected;
   reg  [7:0]   transmit_queue_count, receive_queue_count, frequency_offset_value, preamble_quality;
   reg  [7:0]   live_signal_strength, source_address_byte, destination_address_byte;
   reg  [3:0]   rc_trim_word_result, retransmission_count;
   reg  [4:0]   rc_feedback_word_result;
   reg  [14:0]  synth_amplitude_therm, received_length;
   reg  [126:0] synth_capbank_therm;
   reg  [1:0]   transmit_sequence_number, received_sequence_number;
   reg  [31:0]  check_bytes, irq_level;
   integer      n_errors, comparisons, i, j, k, m;
   rsb_status_bank #(.PART_CODE(8'hA7), .REV_CODE(8'h02)) dut_u (.*);
   rsb_host host_u (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task check(input [7:0] seen, input [7:0] want);
      comparisons = comparisons + 1;
      if (seen !== want) begin
         n_errors = n_errors + 1;
         $display("unexpected at %0t: read %h, wanted %h", $time, seen, want);
      end
   endtask
   task wrap_up;
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // monitor: each live read is answered at the next rising edge
   always @(posedge clk) if (req_live === 1'b1) begin
      #1 check(rd_data, host_u.exp_q.pop_front());
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_errors = n_errors + 1;
      wrap_up;
   end
   initial begin
      {n_errors, comparisons, rst_b} = 65'h0;
      {controller_state, sync_quality, crystal_osc_running, cal_error, antenna_select, cal_ok, tx_book_update,
       pkt_done, received_negative_ack, carrier_sense, sync_detected, transmit_queue_count, receive_queue_count,
       frequency_offset_value, preamble_quality, live_signal_strength, source_address_byte,
       destination_address_byte, rc_trim_word_result, retransmission_count, rc_feedback_word_result,
       synth_amplitude_therm, received_length, synth_capbank_therm, transmit_sequence_number,
       received_sequence_number, check_bytes, irq_level} = 0;
      void'($urandom(32'h156c));
      repeat (5) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      host_u.idle;
      // captured fields and unmapped holes read zero after reset
      for (i = 8'h9C; i <= 8'hAB; i++) host_u.rd(i[7:0], 8'h00);
      for (i = 0; i < 4; i++) begin
         host_u.idle;
         {controller_state, crystal_osc_running, cal_error, antenna_select, cal_ok} = $urandom;
         {transmit_queue_count, rc_trim_word_result, rc_feedback_word_result, frequency_offset_value} = $urandom;
         {live_signal_strength, irq_level} = {$urandom, $urandom};
         receive_queue_count = (i == 0) ? 8'h00 : $urandom;
         k = (i == 1) ? 15 : $urandom_range(14, 0);
         m = (i == 1) ? 127 : $urandom_range(126, 0);
         synth_amplitude_therm = (15'h1 << k) - 15'h1;
         synth_capbank_therm = (127'h1 << m) - 127'h1;
         host_u.idle;
         host_u.rd(8'h8D, {3'b000, antenna_select, cal_ok, 1'b0, receive_queue_count == 8'h00, cal_error});
         host_u.rd(8'h8E, {controller_state, crystal_osc_running});
         host_u.rd(8'h8F, transmit_queue_count);
         host_u.rd(8'h90, receive_queue_count);
         host_u.rd(8'h94, {rc_trim_word_result, rc_feedback_word_result[4:1]});
         host_u.rd(8'h95, {rc_feedback_word_result[0], 7'h00});
         host_u.rd(8'h99, k[7:0]);
         host_u.rd(8'h9A, m[7:0]);
         host_u.rd(8'h9E, frequency_offset_value);
         host_u.rd(8'hEF, live_signal_strength);
         for (j = 0; j < 4; j++) host_u.rd(8'hFA + j[7:0], irq_level[31-8*j -: 8]);
         host_u.rd(8'h9B, 8'h00);
      end
      // strobes capture, then inputs flip and the captured values must hold
      host_u.idle;
      {transmit_sequence_number, retransmission_count, received_negative_ack, received_sequence_number} = $urandom;
      {preamble_quality, sync_quality, carrier_sense, received_length, check_bytes} = {$urandom, $urandom};
      {source_address_byte, destination_address_byte} = $urandom;
      {tx_book_update, pkt_done, sync_detected} = 3'b111;
      host_u.rd(8'hA2, live_signal_strength);
      {tx_book_update, pkt_done, sync_detected} = 3'b000;
      {transmit_sequence_number, retransmission_count, received_negative_ack, received_sequence_number} =
         ~{transmit_sequence_number, retransmission_count, received_negative_ack, received_sequence_number};
      {preamble_quality, sync_quality, carrier_sense, received_length, check_bytes, live_signal_strength} =
         ~{preamble_quality, sync_quality, carrier_sense, received_length, check_bytes, live_signal_strength};
      {source_address_byte, destination_address_byte} = ~{source_address_byte, destination_address_byte};
      host_u.rd(8'h9D, {5'h00, ~received_negative_ack, ~received_sequence_number});
      host_u.rd(8'h9C, {2'b00, ~transmit_sequence_number, ~retransmission_count});
      host_u.rd(8'h9F, ~preamble_quality);
      host_u.rd(8'hA0, {~carrier_sense, ~sync_quality});
      host_u.rd(8'hA2, ~live_signal_strength);
      host_u.rd(8'hA4, {1'b0, ~received_length[14:8]});
      host_u.rd(8'hA5, ~received_length[7:0]);
      for (j = 0; j < 4; j++) host_u.rd(8'hA6 + j[7:0], ~check_bytes[31-8*j -: 8]);
      host_u.rd(8'hAA, ~source_address_byte);
      host_u.rd(8'hAB, ~destination_address_byte);
      host_u.rd(8'hEF, live_signal_strength);
      // writes to the part code and tx bookkeeping registers are ignored
      host_u.wr(8'hF0, 8'h00);
      host_u.wr(8'h9C, 8'hFF);
      host_u.rd(8'hF0, 8'hA7);
      host_u.rd(8'hF1, 8'h02);
      host_u.rd(8'h9C, {2'b00, ~transmit_sequence_number, ~retransmission_count});
      host_u.idle;
      host_u.idle;
      wrap_up;
   end
endmodule // test_radio_status_register_bank
